// ===== src/sim_detect_pkg.sv
// Purpose: shared constants and types for card presence detection
// Assumes: 20 MHz system clock
// Notes: times kept in their own unit, cycle counts derived from them
package sim_detect_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  // least settle time of a detect level before it is believed
  localparam int FILTER_TIME_NS = 100000;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_W = 12;
  // card clock is the system clock divided by this (even)
  localparam int CARD_CLK_DIV = 4;
  localparam int DIV_W = 2;
  // card reset held low this many card clocks after the clock starts
  localparam int RST_HOLD_CARD_CLKS = 512;
  localparam int RST_HOLD_CYCLES = RST_HOLD_CARD_CLKS * CARD_CLK_DIV;
  localparam int HOLD_W = 12;

  // ************************************************************
  // reset values and sizes
  // ************************************************************
  localparam int NUM_CARDS = 2;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic POLARITY_RESET = 1'b1;
  localparam logic LEVEL_RESET = 1'b0;

  // ************************************************************
  // card service states
  // ************************************************************
  typedef enum logic [2:0] {
    SVC_IDLE = 3'b001,
    SVC_RESET = 3'b010,
    SVC_ACTIVE = 3'b100
  } svc_state_type;

endpackage

// ===== src/detect_lane_if.sv
// Purpose: carries one detect pin and its filtered result between modules
// Assumes: single clock domain after the synchroniser in the lane
// Notes: rise and fall are one-cycle pulses
`timescale 1ns/1ps
interface detect_lane_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport lane (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

// ===== src/detect_lane.sv
// Purpose: synchronise and debounce one card-detect pin, flag its edges
// Assumes: raw pin asynchronous to clk_sys
// Notes: level starts low, matching the default pull-down
`timescale 1ns/1ps
module detect_lane #(
  parameter int FILTER_CYCLES_P = sim_detect_pkg::FILTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  detect_lane_if.lane lane
);

  initial begin
    if (FILTER_CYCLES_P < 1 || FILTER_CYCLES_P >= (1 << sim_detect_pkg::FILTER_W)) begin
      $error("filter count out of range");
    end
  end

  localparam logic [sim_detect_pkg::FILTER_W-1:0] CNT_LAST =
    sim_detect_pkg::FILTER_W'(FILTER_CYCLES_P - 1);

  logic sync1_r, sync2_r;
  logic level_r, level_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;
  logic [sim_detect_pkg::FILTER_W-1:0] cnt_r, cnt_nxt;

  // ************************************************************
  // settle filter
  // ************************************************************
  // a level must hold for the whole window; bounce restarts it
  always_comb begin
    level_nxt = level_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    cnt_nxt = '0;
    if (sync2_r != level_r) begin
      if (cnt_r == CNT_LAST) begin
        level_nxt = sync2_r;
        rise_nxt = sync2_r;
        fall_nxt = !sync2_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= sim_detect_pkg::LEVEL_RESET;
      sync2_r <= sim_detect_pkg::LEVEL_RESET;
      level_r <= sim_detect_pkg::LEVEL_RESET;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      sync1_r <= lane.raw;
      sync2_r <= sync1_r;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign lane.level = level_r;
  assign lane.rise = rise_r;
  assign lane.fall = fall_r;

  a_level_needs_settle: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (level_r != $past(level_r)) |-> ($past(cnt_r) == CNT_LAST && $past(sync2_r) == level_r))
    else $error("level moved before filter window ended");

  a_edge_pulse_match: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (sync2_r != level_r && cnt_r == CNT_LAST) |=> ((rise_r && level_r) || (fall_r && !level_r)))
    else $error("settled edge not flagged");

endmodule

// ===== src/sim_card_presence_detect.sv
// Purpose: card presence detection and card line service for two card slots
// Assumes: config and service requests come from logic on clk_sys
// Notes: config applies in the first cycle after reset and at restart; detect pins and card data are synchronised
`timescale 1ns/1ps

// Overview of operation
// - hot-plug detection disabled after reset
// - pull-up only while detection enabled, else pull-down
// - config changes apply only at next restart
// - presence reported by interrupt from detect edges
// - high polarity: rise inserts, fall removes
// - low polarity: fall inserts, rise removes
// - two slots, only one served at once
// - drive card clock, reset, open-drain data
module sim_card_presence_detect #(
  parameter int FILTER_CYCLES_P = sim_detect_pkg::FILTER_CYCLES,
  parameter int RST_HOLD_P = sim_detect_pkg::RST_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hotplug_enable_cfg,
  input wire logic hotplug_polarity_cfg,
  input wire logic module_restart_req,
  input wire logic card_detect_first,
  input wire logic card_detect_second,
  output logic pullup_first,
  output logic pullup_second,
  output logic [1:0] card_inserted,
  output logic [1:0] card_removed,
  output logic presence_irq,
  input wire logic card_activate,
  input wire logic card_select,
  input wire logic tx_drive,
  input wire logic tx_data,
  output logic rx_data,
  output logic card_clock_first,
  output logic card_reset_first,
  input wire logic card_io_first_i,
  output logic card_io_first_o,
  output logic card_io_first_oe,
  output logic card_clock_second,
  output logic card_reset_second,
  input wire logic card_io_second_i,
  output logic card_io_second_o,
  output logic card_io_second_oe
);

  initial begin
    if (RST_HOLD_P < 1 || RST_HOLD_P >= (1 << sim_detect_pkg::HOLD_W)) begin
      $error("reset hold count out of range");
    end
  end

  localparam logic [sim_detect_pkg::HOLD_W-1:0] HOLD_LAST =
    sim_detect_pkg::HOLD_W'(RST_HOLD_P - 1);
  localparam logic [sim_detect_pkg::DIV_W-1:0] DIV_LAST =
    sim_detect_pkg::DIV_W'(sim_detect_pkg::CARD_CLK_DIV / 2 - 1);

  // ************************************************************
  // detect lanes
  // ************************************************************
  logic [1:0] pin_raw, lane_level, lane_rise, lane_fall;
  assign pin_raw = {card_detect_second, card_detect_first};

  for (genvar i = 0; i < sim_detect_pkg::NUM_CARDS; i++) begin : g_lane
    detect_lane_if lane_bus ();
    assign lane_bus.raw = pin_raw[i];
    assign lane_level[i] = lane_bus.level;
    assign lane_rise[i] = lane_bus.rise;
    assign lane_fall[i] = lane_bus.fall;
    detect_lane #(.FILTER_CYCLES_P(FILTER_CYCLES_P)) u_lane (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .lane(lane_bus.lane)
    );
  end

  // ************************************************************
  // config capture and presence events
  // ************************************************************
  logic init_done_r, init_done_nxt;
  logic en_r, en_nxt;
  logic pol_r, pol_nxt;
  logic [1:0] ins_r, ins_nxt;
  logic [1:0] rem_r, rem_nxt;
  logic irq_r, irq_nxt;
  logic load;

  // config is only sampled in the first cycle after reset or on restart,
  // so a change made while running waits for the next restart
  always_comb begin
    init_done_nxt = 1'b1;
    load = !init_done_r || module_restart_req;
    en_nxt = load ? hotplug_enable_cfg : en_r;
    pol_nxt = load ? hotplug_polarity_cfg : pol_r;
    for (int i = 0; i < sim_detect_pkg::NUM_CARDS; i++) begin
      ins_nxt[i] = en_r && (pol_r ? lane_rise[i] : lane_fall[i]);
      rem_nxt[i] = en_r && (pol_r ? lane_fall[i] : lane_rise[i]);
    end
    irq_nxt = (|ins_nxt) || (|rem_nxt);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      init_done_r <= 1'b0;
      en_r <= sim_detect_pkg::ENABLE_RESET;
      pol_r <= sim_detect_pkg::POLARITY_RESET;
      ins_r <= '0;
      rem_r <= '0;
      irq_r <= 1'b0;
    end else begin
      init_done_r <= init_done_nxt;
      en_r <= en_nxt;
      pol_r <= pol_nxt;
      ins_r <= ins_nxt;
      rem_r <= rem_nxt;
      irq_r <= irq_nxt;
    end
  end

  // pull-down unless detection active; both pins follow the one enable
  assign pullup_first = en_r;
  assign pullup_second = en_r;
  assign card_inserted = ins_r;
  assign card_removed = rem_r;
  assign presence_irq = irq_r;

  // ************************************************************
  // card service
  // ************************************************************
  sim_detect_pkg::svc_state_type state_r, state_nxt;
  logic sel_r, sel_nxt;
  logic [sim_detect_pkg::HOLD_W-1:0] hold_r, hold_nxt;
  logic [sim_detect_pkg::DIV_W-1:0] div_r, div_nxt;
  logic ph_r, ph_nxt;
  logic [1:0] clk_out_r, clk_out_nxt;
  logic [1:0] rst_out_r, rst_out_nxt;
  logic [1:0] oe_r, oe_nxt;
  logic [1:0] io_s1_r, io_s2_r;
  logic rx_r, rx_nxt;

  // one slot at a time: the selection is frozen until service ends
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    hold_nxt = hold_r;
    div_nxt = '0;
    ph_nxt = 1'b0;
    if (state_r != sim_detect_pkg::SVC_IDLE) begin
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
      ph_nxt = (div_r == DIV_LAST) ? !ph_r : ph_r;
    end
    case (state_r)
      sim_detect_pkg::SVC_IDLE: begin
        hold_nxt = '0;
        if (card_activate) begin
          sel_nxt = card_select;
          state_nxt = sim_detect_pkg::SVC_RESET;
        end
      end
      sim_detect_pkg::SVC_RESET: begin
        hold_nxt = hold_r + 1'b1;
        if (!card_activate) begin
          state_nxt = sim_detect_pkg::SVC_IDLE;
        end else if (hold_r == HOLD_LAST) begin
          state_nxt = sim_detect_pkg::SVC_ACTIVE;
        end
      end
      sim_detect_pkg::SVC_ACTIVE: begin
        if (!card_activate) begin
          state_nxt = sim_detect_pkg::SVC_IDLE;
        end
      end
      default: begin
        state_nxt = sim_detect_pkg::SVC_IDLE;
      end
    endcase
    for (int i = 0; i < sim_detect_pkg::NUM_CARDS; i++) begin
      clk_out_nxt[i] = (state_r != sim_detect_pkg::SVC_IDLE) && (sel_r == i[0]) && ph_r;
      rst_out_nxt[i] = (state_r == sim_detect_pkg::SVC_ACTIVE) && (sel_r == i[0]);
      oe_nxt[i] = (state_r == sim_detect_pkg::SVC_ACTIVE) && (sel_r == i[0])
        && tx_drive && !tx_data;
    end
    rx_nxt = sel_r ? io_s2_r[1] : io_s2_r[0];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= sim_detect_pkg::SVC_IDLE;
      sel_r <= 1'b0;
      hold_r <= '0;
      div_r <= '0;
      ph_r <= 1'b0;
      clk_out_r <= '0;
      rst_out_r <= '0;
      oe_r <= '0;
      io_s1_r <= 2'h3;
      io_s2_r <= 2'h3;
      rx_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      hold_r <= hold_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      clk_out_r <= clk_out_nxt;
      rst_out_r <= rst_out_nxt;
      oe_r <= oe_nxt;
      io_s1_r <= {card_io_second_i, card_io_first_i};
      io_s2_r <= io_s1_r;
      rx_r <= rx_nxt;
    end
  end

  // open-drain data: only ever pulls low
  assign card_clock_first = clk_out_r[0];
  assign card_clock_second = clk_out_r[1];
  assign card_reset_first = rst_out_r[0];
  assign card_reset_second = rst_out_r[1];
  assign card_io_first_o = 1'b0;
  assign card_io_second_o = 1'b0;
  assign card_io_first_oe = oe_r[0];
  assign card_io_second_oe = oe_r[1];
  assign rx_data = rx_r;

  // ************************************************************
  // checks
  // ************************************************************
  a_disabled_no_event: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !en_r |=> (ins_r == 2'h0 && rem_r == 2'h0 && !irq_r))
    else $error("presence event while detection disabled");

  a_pullup_at_load: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (pullup_first != $past(pullup_first)) |-> ($past(load) && pullup_first == pullup_second))
    else $error("pull-up changed outside restart");

  a_config_held_run: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (init_done_r && !module_restart_req) |=> (en_r == $past(en_r) && pol_r == $past(pol_r)))
    else $error("config applied without restart");

  a_irq_follows_event: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (en_r && (lane_rise != 2'h0 || lane_fall != 2'h0)) |=> presence_irq ##1 !presence_irq)
    else $error("edge did not give one interrupt pulse");

  a_high_pol_insert: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (en_r && pol_r && lane_rise[0]) |=> (card_inserted[0] && !card_removed[0]))
    else $error("high polarity rise not taken as insertion");

  a_low_pol_insert: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (en_r && !pol_r && lane_fall[1]) |=> (card_inserted[1] && !card_removed[1]))
    else $error("low polarity fall not taken as insertion");

  a_one_slot_live: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $onehot0(clk_out_r | rst_out_r | oe_r) || (clk_out_r | rst_out_r | oe_r) == 2'h0)
    else $error("both card slots driven at once");

  a_reset_after_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(state_r == sim_detect_pkg::SVC_ACTIVE) |-> ($past(hold_r) == HOLD_LAST)
      ##1 rst_out_r[sel_r])
    else $error("card reset released before hold time");

endmodule

// ===== dv/card_connector_model.sv
// Purpose: card connector with presence switch on one card slot
// Assumes: pad pull level follows the design's pull-up control
// Notes: no clock of its own, a pure wiring model
`timescale 1ns/1ps
module card_connector_model (
  input wire logic present,
  input wire logic normally_closed,
  input wire logic bounce,
  input wire logic pull_up_on,
  input wire logic io_oe,
  input wire logic card_pull,
  output logic detect,
  output logic io_level
);
  // ************************************************************
  // presence switch
  // ************************************************************
  logic pad_level;
  logic switch_level;
  // an open switch leaves the pin to the pad pull, never a held value
  assign pad_level = pull_up_on;
  assign switch_level = normally_closed ? (present ? pad_level : 1'b0)
                                        : (present ? 1'b0 : pad_level);
  // bounce inverts the pin for as long as the bench holds it
  assign detect = switch_level ^ bounce;

  // ************************************************************
  // data line, pulled up near the connector
  // ************************************************************
  assign io_level = !(io_oe || card_pull);
endmodule

// ===== dv/sim_card_presence_detect_tb_top.sv
// Purpose: self-checking bench for card presence detection and card service
// Assumes: short filter and reset hold parameters for a quick run
// Notes: inputs change 5 ns after the rising edge
`timescale 1ns/1ps
module sim_card_presence_detect_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic en_cfg = 1'b0;
  logic pol_cfg = 1'b1;
  logic restart = 1'b0;
  logic [1:0] pres = 2'b00;
  logic [1:0] nc = 2'b11;
  logic [1:0] bnc = 2'b00;
  logic [1:0] card_pull = 2'b00;
  logic activate = 1'b0;
  logic select = 1'b0;
  logic tx_drive = 1'b0;
  logic tx_data = 1'b1;
  logic pullup_first, pullup_second, presence_irq, rx_data;
  logic [1:0] card_inserted, card_removed, det, io_in;
  logic clk1, rst1, oe1, clk2, rst2, oe2, io1_o, io2_o;
  logic watch2 = 1'b0;
  logic seen2 = 1'b0;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // ************************************************************
  // design and connectors
  // ************************************************************
  sim_card_presence_detect #(.FILTER_CYCLES_P(4), .RST_HOLD_P(8)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .hotplug_enable_cfg(en_cfg),
    .hotplug_polarity_cfg(pol_cfg), .module_restart_req(restart),
    .card_detect_first(det[0]), .card_detect_second(det[1]),
    .pullup_first(pullup_first), .pullup_second(pullup_second),
    .card_inserted(card_inserted), .card_removed(card_removed),
    .presence_irq(presence_irq), .card_activate(activate), .card_select(select),
    .tx_drive(tx_drive), .tx_data(tx_data), .rx_data(rx_data),
    .card_clock_first(clk1), .card_reset_first(rst1), .card_io_first_i(io_in[0]),
    .card_io_first_o(io1_o), .card_io_first_oe(oe1), .card_clock_second(clk2),
    .card_reset_second(rst2), .card_io_second_i(io_in[1]), .card_io_second_o(io2_o),
    .card_io_second_oe(oe2));
  card_connector_model slot_a (.present(pres[0]), .normally_closed(nc[0]),
    .bounce(bnc[0]), .pull_up_on(pullup_first), .io_oe(oe1), .card_pull(card_pull[0]),
    .detect(det[0]), .io_level(io_in[0]));
  card_connector_model slot_b (.present(pres[1]), .normally_closed(nc[1]),
    .bounce(bnc[1]), .pull_up_on(pullup_second), .io_oe(oe2), .card_pull(card_pull[1]),
    .detect(det[1]), .io_level(io_in[1]));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // unserved slot must stay silent while the first is served
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (watch2) seen2 <= seen2 | clk2 | rst2 | oe2;
    if (cycles == 5000) begin
      errors = errors + 1;
      results();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pair(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cfg_restart(input logic en, input logic pol);
    en_cfg = en;
    pol_cfg = pol;
    restart = 1'b1;
    step(1);
    restart = 1'b0;
  endtask

  // bounded wait, then the pulse must last exactly one cycle
  task automatic expect_event(input logic [1:0] ins, input logic [1:0] rem);
    int i;
    for (i = 0; i < 30 && card_inserted === 2'b00 && card_removed === 2'b00; i++) step(1);
    check_pair(card_inserted, ins);
    check_pair(card_removed, rem);
    check_bit(presence_irq, 1'b1);
    step(1);
    check_pair(card_inserted | card_removed, 2'b00);
  endtask

  task automatic expect_quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      step(1);
      seen = seen | presence_irq | (|card_inserted) | (|card_removed);
    end
    check_bit(seen, 1'b0);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_disabled_default();
    step(20);
    check_pair({pullup_second, pullup_first}, 2'b00);
    check_bit(rx_data, 1'b1);
    reset_n = 1'b1;
    step(2);
    check_pair({pullup_second, pullup_first}, 2'b00);
    pres[0] = 1'b1;
    // bounce long enough to pass the filter: lane edges, still no event
    bnc[0] = 1'b1;
    expect_quiet(12);
    bnc[0] = 1'b0;
    expect_quiet(20);
  endtask

  task automatic t_high_polarity();
    en_cfg = 1'b1;
    step(3);
    check_bit(pullup_first, 1'b0);
    cfg_restart(1'b1, 1'b1);
    check_pair({pullup_second, pullup_first}, 2'b11);
    expect_event(2'b01, 2'b00);
    pres[0] = 1'b0;
    expect_event(2'b00, 2'b01);
    bnc[0] = 1'b1;
    step(2);
    bnc[0] = 1'b0;
    expect_quiet(20);
    pres = 2'b11;
    expect_event(2'b11, 2'b00);
    pres = 2'b00;
    expect_event(2'b00, 2'b11);
  endtask

  task automatic t_low_polarity();
    cfg_restart(1'b1, 1'b0);
    nc = 2'b00;
    expect_event(2'b00, 2'b11);
    pres[1] = 1'b1;
    expect_event(2'b10, 2'b00);
    pres[1] = 1'b0;
    expect_event(2'b00, 2'b10);
    cfg_restart(1'b0, 1'b0);
    check_pair({pullup_second, pullup_first}, 2'b00);
    expect_quiet(20);
  endtask

  task automatic t_card_service();
    int highs;
    highs = 0;
    watch2 = 1'b1;
    activate = 1'b1;
    select = 1'b0;
    step(4);
    check_bit(rst1, 1'b0);
    repeat (8) begin
      step(1);
      highs += int'(clk1);
    end
    check_bit(highs == 4, 1'b1);
    check_bit(rst1, 1'b1);
    tx_drive = 1'b1;
    tx_data = 1'b0;
    step(2);
    check_bit(oe1, 1'b1);
    check_pair({io2_o, io1_o}, 2'b00);
    step(3);
    check_bit(rx_data, 1'b0);
    tx_data = 1'b1;
    step(5);
    check_bit(oe1, 1'b0);
    check_bit(rx_data, 1'b1);
    card_pull[0] = 1'b1;
    step(5);
    check_bit(rx_data, 1'b0);
    card_pull[0] = 1'b0;
    activate = 1'b0;
    step(2);
    check_bit(clk1 | rst1 | oe1, 1'b0);
    watch2 = 1'b0;
    check_bit(seen2, 1'b0);
    select = 1'b1;
    activate = 1'b1;
    highs = 0;
    step(6);
    repeat (8) begin
      step(1);
      highs += int'(clk2);
    end
    check_bit(highs == 4, 1'b1);
    check_pair({rst2, rst1}, 2'b10);
    tx_data = 1'b0;
    step(2);
    check_bit(oe2, 1'b1);
    tx_data = 1'b1;
    card_pull[1] = 1'b1;
    step(5);
    check_bit(rx_data, 1'b0);
    card_pull[1] = 1'b0;
    activate = 1'b0;
    step(2);
    check_bit(clk2 | rst2, 1'b0);
  endtask

  // ************************************************************
  // sequence and verdict
  // ************************************************************
  task automatic results();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    t_disabled_default();
    t_high_polarity();
    t_low_polarity();
    t_card_service();
    results();
  end
endmodule
